// ===== core/current_limit_hiccup_pkg.sv
// constants and types shared by both ends of the current limit and sync block
// What this block does
// RULE1 - end the pulse when current reaches limit
// RULE2 - filter current sense for about 30 ns
// RULE3 - trip to outputs off takes 100 ns
// RULE4 - limit discharge current depends on duty, role
// RULE5 - limit time from 4.65 to 3.7 V
// RULE6 - off time charges 0.55 to 3.6 V
// RULE7 - start-up overcurrent: keep charging, then pull up
// RULE8 - latch-off strap stops switching for good
// RULE9 - latch cleared by forced node or lockout
// RULE10 - leader drives sync at twice frequency, half duty
// RULE11 - follower never drives the sync line
// RULE12 - follower aligns its clock to falling edges
// RULE13 - sync frequency at least 1.8 times follower's
// RULE14 - follower waits for one sync pulse
// RULE15 - follower free-runs when sync pulses stop
// RULE16 - leader sync starts after 0.55 V enable
// RULE17 - follower ramps soft-start before any pulse
// RULE18 - leader enables first, equal pulse settings
// RULE19 - role chosen by resistor straps
// RULE20 - comparators are synced bits, phases are states
package current_limit_hiccup_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNC_STAGES = 2;
	localparam int CS_FILTER_NS = 30;
	localparam int CS_FILTER_CYC = (CS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_TRIP_LATENCY_NS = 100;
	localparam int LIMIT_TRIP_LATENCY_CYC = LIMIT_TRIP_LATENCY_NS / CLK_PERIOD_NS;
	// remaining delay after the synchroniser, the filter and the output flop
	localparam int CS_PIPE_CYC = LIMIT_TRIP_LATENCY_CYC - SYNC_STAGES - CS_FILTER_CYC - 1;

	// discharge current in nA: gain times (1-D), leader subtracts offset
	localparam int DS_GAIN_NA = 25000;
	localparam int DS_LEADER_OFFSET_NA = 5000;
	localparam int DS_WIDTH = 16;

	// sync line runs at this multiple of the switching frequency
	localparam int SYNC_FREQ_RATIO = 2;
	localparam int SYNC_MIN_RATIO_X10 = 18;

	// comparator bit positions on the analog input vector
	localparam int CMP_CS_LIMIT = 0;
	localparam int CMP_SS_055 = 1;
	localparam int CMP_SS_360 = 2;
	localparam int CMP_SS_370 = 3;
	localparam int CMP_SS_465 = 4;
	localparam int CMP_COUNT = 5;

	localparam int SW_PERIOD_CYC_DEFAULT = 1000;
	localparam int DEMAND_WIDTH = 10;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SOFTSTART,
		ST_PULLUP,
		ST_RUN,
		ST_LIMIT_ON,
		ST_DRAIN,
		ST_OFF_CHARGE,
		ST_LATCHED
	} hiccup_state_type;

endpackage

// ===== core/phase_lock_if.sv
// shared phase lock line between the device end and its partner controller
`timescale 1ns/1ps
`default_nettype none
interface phase_lock_if;
	logic lead_out;
	logic lead_oe;
	logic dev_out;
	logic dev_oe;
	logic follower_strap;
	logic line;

	// line has a pull-down; either end may drive it high
	assign line = (lead_oe & lead_out) | (dev_oe & dev_out);

	modport device (
		input line,
		input follower_strap,
		output dev_out,
		output dev_oe
	);

	modport partner (
		input line,
		output lead_out,
		output lead_oe,
		output follower_strap
	);
endinterface
`default_nettype wire

// ===== core/hiccup_sync_device.sv
// controller end: cycle limit, hiccup sequencing, latch-off and sync lock
`timescale 1ns/1ps
`default_nettype none
module hiccup_sync_device #(
	parameter int SW_PERIOD_CYC = current_limit_hiccup_pkg::SW_PERIOD_CYC_DEFAULT
) (
	input wire logic clock_i, // system clock
	input wire logic srst_i, // sync reset, also supply lockout
	phase_lock_if.device sync, // shared sync line
	input wire logic [current_limit_hiccup_pkg::CMP_COUNT-1:0] cmp_i, // raw comparator levels
	input wire logic latch_strap_i, // latch-off pull-up fitted
	input wire logic [current_limit_hiccup_pkg::DEMAND_WIDTH-1:0] demand_i, // wanted pulse width, cycles
	output logic bridge_a_o, // first half-cycle pulse
	output logic bridge_b_o, // second half-cycle pulse
	output logic ss_charge_o, // normal soft-start charge
	output logic ss_small_charge_o, // off-time small charge
	output logic ss_sink_o, // duty-dependent discharge on
	output logic [current_limit_hiccup_pkg::DS_WIDTH-1:0] ss_sink_na_o, // discharge current, nA
	output logic ss_fast_up_o, // quick pull to upper level
	output logic ss_fast_down_o, // quick drain to enable level
	output logic latched_o, // latch-off active
	output logic locked_o, // follower has seen a sync pulse
	output logic [3:0] state_o // hiccup phase
);
	localparam int HALF_CYC = SW_PERIOD_CYC / 2;
	localparam int SYNC_HALF_CYC = SW_PERIOD_CYC / (2 * current_limit_hiccup_pkg::SYNC_FREQ_RATIO);
	localparam int CW = $clog2(HALF_CYC + 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);
	localparam logic [CW-1:0] SYNC_LAST = CW'(SYNC_HALF_CYC - 1);
	localparam int FW = 3;
	localparam logic [FW-1:0] FILT_LAST = FW'(current_limit_hiccup_pkg::CS_FILTER_CYC - 1);
	localparam int PIPE = current_limit_hiccup_pkg::CS_PIPE_CYC;
	// local names for the shared phase encoding
	typedef current_limit_hiccup_pkg::hiccup_state_type hiccup_state_type;
	localparam hiccup_state_type ST_IDLE = current_limit_hiccup_pkg::ST_IDLE;
	localparam hiccup_state_type ST_SOFTSTART = current_limit_hiccup_pkg::ST_SOFTSTART;
	localparam hiccup_state_type ST_PULLUP = current_limit_hiccup_pkg::ST_PULLUP;
	localparam hiccup_state_type ST_RUN = current_limit_hiccup_pkg::ST_RUN;
	localparam hiccup_state_type ST_LIMIT_ON = current_limit_hiccup_pkg::ST_LIMIT_ON;
	localparam hiccup_state_type ST_DRAIN = current_limit_hiccup_pkg::ST_DRAIN;
	localparam hiccup_state_type ST_OFF_CHARGE = current_limit_hiccup_pkg::ST_OFF_CHARGE;
	localparam hiccup_state_type ST_LATCHED = current_limit_hiccup_pkg::ST_LATCHED;

	logic [current_limit_hiccup_pkg::CMP_COUNT-1:0] cmp_s1_reg;
	logic [current_limit_hiccup_pkg::CMP_COUNT-1:0] cmp_s2_reg;
	logic [1:0] strap_s1_reg;
	logic [1:0] strap_s2_reg;
	logic follower_reg;
	logic latch_mode_reg;
	logic [FW-1:0] filt_cnt_reg;
	logic trip_filt_reg;
	logic [PIPE-1:0] trip_pipe_reg;
	logic trip_late;
	logic [CW-1:0] osc_cnt_reg;
	logic leg_reg;
	logic pulse_reg;
	logic [CW-1:0] on_cnt_reg;
	logic trip_half_reg;
	logic trip_period_reg;
	logic half_end;
	logic switching;
	hiccup_state_type state_reg;
	hiccup_state_type state_next;
	logic oc_pending_reg;
	logic [CW-1:0] sync_cnt_reg;
	logic sync_out_reg;
	logic sync_oe_reg;
	logic req_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic lock_pulse;
	logic seen_reg;
	logic req_l1_reg;
	logic req_l2_reg;
	logic ack_l_reg;
	logic ss055;
	logic ss360;
	logic ss370;
	logic ss465;
	logic [31:0] sink_calc;

	// analog crossings arrive as plain levels and pass two flops first
	always_ff @(posedge clock_i) begin // RULE20
		cmp_s1_reg <= cmp_i;
		cmp_s2_reg <= cmp_s1_reg;
		strap_s1_reg <= {latch_strap_i, sync.follower_strap};
		strap_s2_reg <= strap_s1_reg;
	end

	assign ss055 = cmp_s2_reg[current_limit_hiccup_pkg::CMP_SS_055];
	assign ss360 = cmp_s2_reg[current_limit_hiccup_pkg::CMP_SS_360];
	assign ss370 = cmp_s2_reg[current_limit_hiccup_pkg::CMP_SS_370];
	assign ss465 = cmp_s2_reg[current_limit_hiccup_pkg::CMP_SS_465];

	// straps are caught while reset holds; changes later are ignored
	always_ff @(posedge clock_i) begin // RULE19
		if (srst_i) begin
			follower_reg <= strap_s2_reg[0];
			latch_mode_reg <= strap_s2_reg[1];
		end
	end

	// spikes shorter than the filter never reach the pipe
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			filt_cnt_reg <= '0;
			trip_filt_reg <= 1'b0;
		end else if (cmp_s2_reg[current_limit_hiccup_pkg::CMP_CS_LIMIT]) begin
			if (filt_cnt_reg != FILT_LAST + FW'(1))
				filt_cnt_reg <= filt_cnt_reg + FW'(1);
			trip_filt_reg <= (filt_cnt_reg >= FILT_LAST); // RULE2
		end else begin
			filt_cnt_reg <= '0;
			trip_filt_reg <= 1'b0;
		end
	end

	// pads the path so pin to output off is a fixed count
	always_ff @(posedge clock_i) begin // RULE3
		if (srst_i)
			trip_pipe_reg <= '0;
		else
			trip_pipe_reg <= {trip_pipe_reg[PIPE-2:0], trip_filt_reg};
	end
	assign trip_late = trip_pipe_reg[PIPE-1];

	// half-cycle oscillator; a follower restarts it on each lock event
	assign half_end = (osc_cnt_reg == HALF_LAST);
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			osc_cnt_reg <= '0;
			leg_reg <= 1'b0;
		end else if (follower_reg && lock_pulse) begin
			osc_cnt_reg <= '0; // RULE12
			leg_reg <= ~leg_reg;
		end else if (half_end) begin
			osc_cnt_reg <= '0; // RULE15
			leg_reg <= ~leg_reg;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + CW'(1);
		end
	end

	assign switching = (state_reg == ST_SOFTSTART || state_reg == ST_PULLUP || state_reg == ST_RUN ||
		state_reg == ST_LIMIT_ON) && (!follower_reg || seen_reg); // RULE14

	// a pulse only starts at a half-cycle start, so a trip ends it for the rest of it
	always_ff @(posedge clock_i) begin
		if (srst_i)
			pulse_reg <= 1'b0;
		else if (!switching || trip_late) // RULE1
			pulse_reg <= 1'b0;
		else if (osc_cnt_reg == '0)
			pulse_reg <= (demand_i != '0);
		else if (CW'(demand_i) <= osc_cnt_reg)
			pulse_reg <= 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			bridge_a_o <= 1'b0;
			bridge_b_o <= 1'b0;
		end else begin
			bridge_a_o <= pulse_reg && !leg_reg && !trip_late;
			bridge_b_o <= pulse_reg && leg_reg && !trip_late;
		end
	end

	// on-time per half-cycle gives the duty for the discharge current
	always_ff @(posedge clock_i) begin
		if (srst_i || half_end)
			on_cnt_reg <= '0;
		else if (pulse_reg)
			on_cnt_reg <= on_cnt_reg + CW'(1);
	end

	always_comb begin
		sink_calc = (32'(current_limit_hiccup_pkg::DS_GAIN_NA) * 32'(CW'(HALF_CYC) - on_cnt_reg)) /
			32'(HALF_CYC);
		if (!follower_reg) begin
			if (sink_calc > 32'(current_limit_hiccup_pkg::DS_LEADER_OFFSET_NA))
				sink_calc = sink_calc - 32'(current_limit_hiccup_pkg::DS_LEADER_OFFSET_NA);
			else
				sink_calc = '0;
		end
	end

	always_ff @(posedge clock_i) begin // RULE4
		if (srst_i)
			ss_sink_na_o <= '0;
		else if (half_end)
			ss_sink_na_o <= sink_calc[current_limit_hiccup_pkg::DS_WIDTH-1:0];
	end

	// a trip anywhere in the current or last half-cycle keeps the limit phase alive
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			trip_half_reg <= 1'b0;
			trip_period_reg <= 1'b0;
		end else if (half_end) begin
			trip_period_reg <= trip_half_reg || trip_filt_reg;
			trip_half_reg <= trip_filt_reg;
		end else if (trip_filt_reg) begin
			trip_half_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin // RULE7
		if (srst_i || state_reg != ST_SOFTSTART)
			oc_pending_reg <= 1'b0;
		else if (trip_filt_reg)
			oc_pending_reg <= 1'b1;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (ss055)
					state_next = ST_SOFTSTART;
			ST_SOFTSTART:
				if (!ss055)
					state_next = ST_IDLE;
				else if (ss370 && (oc_pending_reg || trip_filt_reg))
					state_next = latch_mode_reg ? ST_LATCHED : ST_PULLUP; // RULE7
				else if (ss370)
					state_next = ST_RUN;
			ST_PULLUP:
				if (ss465)
					state_next = ST_LIMIT_ON;
			ST_RUN:
				if (!ss055)
					state_next = ST_IDLE;
				else if (trip_filt_reg)
					state_next = latch_mode_reg ? ST_LATCHED : ST_LIMIT_ON; // RULE8
			ST_LIMIT_ON:
				if (!ss370)
					state_next = ST_DRAIN; // RULE5
				else if (half_end && !trip_period_reg && !trip_half_reg && !trip_filt_reg)
					state_next = ST_RUN;
			ST_DRAIN:
				if (!ss055)
					state_next = ST_OFF_CHARGE;
			ST_OFF_CHARGE:
				if (ss360)
					state_next = ST_SOFTSTART; // RULE6
			ST_LATCHED:
				if (!ss055)
					state_next = ST_IDLE; // RULE9
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i) begin // RULE20
		if (srst_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// node drives follow the phase; a follower charges before any lock
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ss_charge_o <= 1'b0;
			ss_small_charge_o <= 1'b0;
			ss_sink_o <= 1'b0;
			ss_fast_up_o <= 1'b0;
			ss_fast_down_o <= 1'b0;
			latched_o <= 1'b0;
			state_o <= '0;
		end else begin
			ss_charge_o <= (state_next == ST_IDLE || state_next == ST_SOFTSTART ||
				state_next == ST_RUN); // RULE17
			ss_small_charge_o <= (state_next == ST_OFF_CHARGE); // RULE6
			ss_sink_o <= (state_next == ST_LIMIT_ON); // RULE4
			ss_fast_up_o <= (state_next == ST_PULLUP); // RULE7
			ss_fast_down_o <= (state_next == ST_DRAIN); // RULE5
			latched_o <= (state_next == ST_LATCHED); // RULE8
			state_o <= state_next;
		end
	end

	// leader divider: sync runs at twice switching rate, square wave
	always_ff @(posedge clock_i) begin
		if (srst_i || follower_reg || !ss055) begin // RULE16
			sync_cnt_reg <= '0;
			sync_out_reg <= 1'b0;
			sync_oe_reg <= 1'b0; // RULE11
		end else begin
			sync_oe_reg <= 1'b1;
			if (sync_cnt_reg == SYNC_LAST) begin
				sync_cnt_reg <= '0;
				sync_out_reg <= ~sync_out_reg; // RULE10
			end else begin
				sync_cnt_reg <= sync_cnt_reg + CW'(1);
			end
		end
	end
	assign sync.dev_out = sync_out_reg;
	assign sync.dev_oe = sync_oe_reg;

	// link side: echoes the request on falling edges of the line
	always_ff @(negedge sync.line) begin // RULE12
		req_l1_reg <= req_reg;
		req_l2_reg <= req_l1_reg;
		ack_l_reg <= req_l2_reg;
	end

	// request returns only after falling edges arrive; each round trip is one lock event
	always_ff @(posedge clock_i) begin
		ack_s1_reg <= ack_l_reg;
		ack_s2_reg <= ack_s1_reg;
	end
	assign lock_pulse = (ack_s2_reg == req_reg);

	always_ff @(posedge clock_i) begin
		if (srst_i)
			req_reg <= 1'b0;
		else if (lock_pulse)
			req_reg <= ~req_reg;
	end

	// link flops keep no reset, so the first round trip may be stale; only the second proves an edge
	always_ff @(posedge clock_i) begin // RULE14
		if (srst_i)
			seen_reg <= 1'b0;
		else if (follower_reg && lock_pulse && req_reg)
			seen_reg <= 1'b1;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i)
			locked_o <= 1'b0;
		else
			locked_o <= seen_reg;
	end

endmodule // hiccup_sync_device
`default_nettype wire

// ===== core/hiccup_sync_partner.sv
// partner controller end: leader that makes the sync line and sets the follower strap
`timescale 1ns/1ps
`default_nettype none
module hiccup_sync_partner #(
	parameter int SW_PERIOD_CYC = current_limit_hiccup_pkg::SW_PERIOD_CYC_DEFAULT
) (
	input wire logic clock_i, // system clock
	input wire logic srst_i, // sync reset
	phase_lock_if.partner sync, // shared sync line
	input wire logic enable_i, // own soft-start past enable level
	input wire logic follower_strap_i, // request follower role for the device
	output logic leader_active_o // sync pulses being driven
);
	// sync half period from own clock; SYNC_FREQ_RATIO keeps it above 1.8x
	localparam int SYNC_HALF_CYC = SW_PERIOD_CYC / (2 * current_limit_hiccup_pkg::SYNC_FREQ_RATIO);
	localparam int CW = $clog2(SYNC_HALF_CYC + 1);
	localparam logic [CW-1:0] SYNC_LAST = CW'(SYNC_HALF_CYC - 1);

	logic en_s1_reg;
	logic en_s2_reg;
	logic [CW-1:0] div_cnt_reg;
	logic out_reg;
	logic oe_reg;
	logic strap_reg;

	always_ff @(posedge clock_i) begin
		en_s1_reg <= enable_i;
		en_s2_reg <= en_s1_reg;
	end

	// strap resistors are fixed at power-up
	always_ff @(posedge clock_i) begin // RULE19
		if (srst_i)
			strap_reg <= 1'b0;
		else
			strap_reg <= follower_strap_i;
	end

	// starts before the follower's soft-start when enable comes first
	always_ff @(posedge clock_i) begin // RULE18
		if (srst_i || !en_s2_reg) begin
			div_cnt_reg <= '0;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= 1'b1;
			if (div_cnt_reg == SYNC_LAST) begin
				div_cnt_reg <= '0;
				out_reg <= ~out_reg; // RULE13
			end else begin
				div_cnt_reg <= div_cnt_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i)
			leader_active_o <= 1'b0;
		else
			leader_active_o <= oe_reg;
	end

	assign sync.lead_out = out_reg;
	assign sync.lead_oe = oe_reg;
	assign sync.follower_strap = strap_reg;

endmodule // hiccup_sync_partner
`default_nettype wire

// ===== tb/current_limit_hiccup_properties.sv
// concurrent checks on the sync line and the protection outputs
`timescale 1ns/1ps
`default_nettype none
module current_limit_hiccup_properties #(
	parameter int SW_PERIOD_CYC = 40
) (
	input wire logic clock_i, // system clock
	input wire logic srst_i, // device reset
	input wire logic dev_out, // device drive value
	input wire logic dev_oe, // device drive enable
	input wire logic follower_strap, // role strap
	input wire logic bridge_a_o, // first half pulse
	input wire logic bridge_b_o, // second half pulse
	input wire logic ss_sink_o, // discharge on
	input wire logic ss_small_charge_o, // small charge on
	input wire logic ss_fast_up_o, // quick pull up
	input wire logic ss_fast_down_o, // quick drain
	input wire logic latched_o, // latch-off
	input wire logic locked_o, // follower locked
	input wire logic [3:0] state_o // hiccup phase
);
	localparam int QTR = SW_PERIOD_CYC / 4;
	logic prev_out;
	logic armed;
	int unsigned hold_cnt;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	// first toggle after enable comes late, after the idle stretch, so only later ones are timed
	always_ff @(posedge clock_i) prev_out <= dev_out;
	always_ff @(posedge clock_i) hold_cnt <= (srst_i || dev_out != prev_out) ? 0 : hold_cnt + 1;
	always_ff @(posedge clock_i) armed <= (srst_i || !dev_oe) ? 1'b0 : (armed || dev_out != prev_out);

	a_follower_never_drives: assert property (follower_strap |-> !dev_oe)
		else $error("follower drives the sync line");
	a_sync_half_period: assert property (dev_oe && armed && dev_out != prev_out |-> hold_cnt == QTR - 1)
		else $error("sync line half period wrong");
	a_unlocked_no_pulse: assert property (follower_strap && !locked_o |-> !bridge_a_o && !bridge_b_o)
		else $error("follower switches before lock");
	a_lock_only_follower: assert property (locked_o |-> follower_strap)
		else $error("lock seen in leader role");
	a_latched_stays_off: assert property (latched_o && $past(latched_o, 2) |-> !bridge_a_o && !bridge_b_o)
		else $error("switching while latched off");
	a_limit_sinks: assert property (state_o == current_limit_hiccup_pkg::ST_LIMIT_ON && $past(state_o) == state_o
		|-> ss_sink_o)
		else $error("no discharge during limit time");
	a_drain_silent: assert property (state_o == current_limit_hiccup_pkg::ST_DRAIN && $past(state_o, 2) == state_o
		|-> ss_fast_down_o && !bridge_a_o && !bridge_b_o)
		else $error("drain phase wrong");
	a_off_small_charge: assert property (state_o == current_limit_hiccup_pkg::ST_OFF_CHARGE
		&& $past(state_o, 2) == state_o |-> ss_small_charge_o && !bridge_a_o && !bridge_b_o)
		else $error("off phase wrong");
	a_pullup_fast: assert property (state_o == current_limit_hiccup_pkg::ST_PULLUP && $past(state_o) == state_o
		|-> ss_fast_up_o)
		else $error("no quick pull up");
endmodule // current_limit_hiccup_properties
`default_nettype wire

// ===== tb/current_limit_hiccup_sync_tb.sv
// bench joining the device end and the partner end over the sync line
`timescale 1ns/1ps
`default_nettype none
module current_limit_hiccup_sync_tb;
	localparam int SW = 40;
	typedef struct {logic [4:0] cmp; int cyc; logic [3:0] st;} row_type;
	logic clock_i, dev_srst, par_srst, latch_strap, enable, strap, line;
	logic bridge_a, bridge_b, ss_charge, ss_small, ss_sink, ss_up, ss_down, latched, locked, leader_active;
	logic [4:0] cmp;
	logic [9:0] demand;
	logic [15:0] sink_na;
	logic [3:0] state;
	int error_cnt, checks, n;
	row_type rows [10] = '{'{5'h02, 5, current_limit_hiccup_pkg::ST_SOFTSTART},
		'{5'h0E, 5, current_limit_hiccup_pkg::ST_RUN}, '{5'h0F, 30, current_limit_hiccup_pkg::ST_LIMIT_ON},
		'{5'h06, 5, current_limit_hiccup_pkg::ST_DRAIN}, '{5'h00, 5, current_limit_hiccup_pkg::ST_OFF_CHARGE},
		'{5'h06, 5, current_limit_hiccup_pkg::ST_SOFTSTART}, '{5'h0E, 5, current_limit_hiccup_pkg::ST_RUN},
		'{5'h0F, 30, current_limit_hiccup_pkg::ST_LIMIT_ON}, '{5'h0E, 70, current_limit_hiccup_pkg::ST_RUN},
		'{5'h00, 5, current_limit_hiccup_pkg::ST_IDLE}};

	phase_lock_if u_phase_lock_if();
	assign line = u_phase_lock_if.line;

	hiccup_sync_device #(.SW_PERIOD_CYC(SW)) u_hiccup_sync_device (.clock_i(clock_i), .srst_i(dev_srst),
		.sync(u_phase_lock_if.device), .cmp_i(cmp), .latch_strap_i(latch_strap), .demand_i(demand),
		.bridge_a_o(bridge_a), .bridge_b_o(bridge_b), .ss_charge_o(ss_charge), .ss_small_charge_o(ss_small),
		.ss_sink_o(ss_sink), .ss_sink_na_o(sink_na), .ss_fast_up_o(ss_up), .ss_fast_down_o(ss_down),
		.latched_o(latched), .locked_o(locked), .state_o(state));
	hiccup_sync_partner #(.SW_PERIOD_CYC(SW)) u_hiccup_sync_partner (.clock_i(clock_i), .srst_i(par_srst),
		.sync(u_phase_lock_if.partner), .enable_i(enable), .follower_strap_i(strap), .leader_active_o(leader_active));
	current_limit_hiccup_properties #(.SW_PERIOD_CYC(SW)) u_current_limit_hiccup_properties (
		.clock_i(clock_i), .srst_i(dev_srst), .dev_out(u_phase_lock_if.dev_out), .dev_oe(u_phase_lock_if.dev_oe),
		.follower_strap(u_phase_lock_if.follower_strap), .bridge_a_o(bridge_a), .bridge_b_o(bridge_b),
		.ss_sink_o(ss_sink), .ss_small_charge_o(ss_small), .ss_fast_up_o(ss_up), .ss_fast_down_o(ss_down),
		.latched_o(latched), .locked_o(locked), .state_o(state));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// straps are only captured while the device is held in reset
	task automatic do_reset(input logic fol, input logic lat);
		dev_srst = 1'b1;
		par_srst = 1'b1;
		strap = fol;
		latch_strap = lat;
		cmp = 5'h00;
		enable = 1'b0;
		tick(4);
		par_srst = 1'b0;
		tick(4);
		dev_srst = 1'b0;
	endtask

	task automatic wait_rise;
		for (n = 0; n < 99 && bridge_a !== 1'b0; n++) tick(1);
		for (n = 0; n < 99 && bridge_a !== 1'b1; n++) tick(1);
		check(16'(bridge_a), 16'h0001);
	endtask

	initial begin
		#100000;
		error_cnt++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		error_cnt = 0;
		checks = 0;
		demand = 10'h00F;
		do_reset(1'b0, 1'b0);
		tick(20);
		check(16'(u_phase_lock_if.dev_oe), 16'h0000);
		foreach (rows[i]) begin
			cmp = rows[i].cmp;
			tick(rows[i].cyc);
			check(16'(state), 16'(rows[i].st));
		end
		$display("sequence table done");
		do_reset(1'b0, 1'b0);
		cmp = 5'h0E;
		tick(10);
		check(16'(u_phase_lock_if.dev_oe), 16'h0001);
		for (n = 0; n < 99 && line !== 1'b1; n++) tick(1);
		for (n = 0; n < 99 && line !== 1'b0; n++) tick(1);
		for (n = 0; n < 99 && line !== 1'b1; n++) tick(1);
		check(16'(n), 16'(SW / 4));
		for (; n < 99 && line !== 1'b0; n++) tick(1);
		check(16'(n), 16'(SW / 2));
		// a two cycle spike must not cut the pulse short
		wait_rise();
		cmp[0] = 1'b1;
		tick(2);
		cmp[0] = 1'b0;
		tick(9);
		check(16'(bridge_a), 16'h0001);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_RUN));
		wait_rise();
		cmp[0] = 1'b1;
		tick(9);
		check(16'(bridge_a), 16'h0001);
		tick(1);
		check(16'(bridge_a), 16'h0000);
		tick(20);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_LIMIT_ON));
		demand = 10'h000;
		tick(45);
		check(sink_na, 16'h4E20);
		demand = 10'h00F;
		$display("leader limit test done");
		do_reset(1'b0, 1'b0);
		cmp = 5'h03;
		tick(30);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_SOFTSTART));
		check(16'(ss_charge), 16'h0001);
		cmp = 5'h0B;
		tick(5);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_PULLUP));
		cmp = 5'h1B;
		tick(5);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_LIMIT_ON));
		$display("start-up trip test done");
		do_reset(1'b1, 1'b1);
		cmp = 5'h02;
		tick(10);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_SOFTSTART));
		check(16'(locked), 16'h0000);
		check(16'(leader_active), 16'h0000);
		enable = 1'b1;
		for (n = 0; n < 300 && locked !== 1'b1; n++) tick(1);
		check(16'(locked), 16'h0001);
		check(16'(leader_active), 16'h0001);
		wait_rise();
		// pulses stop: the follower keeps its own oscillator
		enable = 1'b0;
		tick(60);
		check(16'(leader_active), 16'h0000);
		wait_rise();
		cmp = 5'h0F;
		tick(30);
		check(16'(latched), 16'h0001);
		cmp = 5'h1E;
		tick(60);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_LATCHED));
		cmp = 5'h00;
		tick(5);
		check(16'(latched), 16'h0000);
		check(16'(state), 16'(current_limit_hiccup_pkg::ST_IDLE));
		$display("follower latch test done");
		conclude();
	end
endmodule // current_limit_hiccup_sync_tb
`default_nettype wire
